/* core/zts_pkg.sv */
/*
  Shared constants and types for the flow-through synchronous SRAM core
  with no turnaround cycles between reads and writes.
  Assumes a single clock domain; all users import the whole package.
*/
package zts_pkg;

  // Default array geometry: 128K words of four 9-bit byte lanes
  localparam int ADDR_W_DEF = 17;
  localparam int DATA_W_DEF = 36;
  localparam int BYTE_N_DEF = 4;

  // Burst geometry: four words, counter on the two low address bits
  localparam int BURST_LEN = 4;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_CNT_RST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

  // Level on the burst order select pin that picks interleaved order
  localparam logic ORDER_INTERLEAVED = 1'h1;

  // Level of read_write_select that loads a read
  localparam logic RW_READ = 1'h1;

  // Reset value of the registered read data
  localparam int DOUT_RST = 0;

  // Operation whose data phase falls in the next cycle
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } zts_op_t;

endpackage

/* core/zts_sram_core.sv */
/*
  Synchronous flow-through SRAM core: address and control are taken in one
  cycle and the matching data moves in the next, for reads and writes alike,
  with an on-chip four-word burst counter and clock-enable suspension.
  Assumes all inputs are synchronous to clk and that the surrounding
  interface resolves the data wire from dataOut and dataOutEnable.
*/
`timescale 1ns/1ps

module zts_sram_core #(
  parameter int ADDR_W = zts_pkg::ADDR_W_DEF,
  parameter int DATA_W = zts_pkg::DATA_W_DEF,
  parameter int BYTE_N = zts_pkg::BYTE_N_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic readWriteSelect,
  input wire logic advanceOrLoad,
  input wire logic chipSelectLowA,
  input wire logic chipSelectLowB,
  input wire logic chipSelectHigh,
  input wire logic clockEnableN,
  input wire logic [BYTE_N-1:0] byteWriteStrobeN,
  input wire logic burstOrderSelect,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOutEnable
);
  import zts_pkg::*;

  localparam int BYTE_W = DATA_W / BYTE_N;
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // Operation owed to the next cycle and its burst position
  zts_op_t op;
  logic [ADDR_W-1:0] baseAddr;
  logic [BURST_W-1:0] burstCnt;
  logic [BYTE_N-1:0] opStrobeN;

  zts_op_t next_op;
  logic [ADDR_W-1:0] next_baseAddr;
  logic [BURST_W-1:0] next_burstCnt;
  logic [BYTE_N-1:0] next_opStrobeN;

  logic selected;
  logic running;
  logic writeNow;
  logic [ADDR_W-1:0] curAddr;
  logic [ADDR_W-1:0] nextAddr;
  logic [DATA_W-1:0] readWord;

  function automatic logic is_selected(input logic lowA, input logic lowB,
                                       input logic high);
    is_selected = !lowA && !lowB && high;
  endfunction

  // Burst address from the loaded base and the count
  function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                   input logic [BURST_W-1:0] cnt,
                                                   input logic order);
    logic [BURST_W-1:0] low;
    low = (order == ORDER_INTERLEAVED) ? (base[BURST_W-1:0] ^ cnt)
                                       : (base[BURST_W-1:0] + cnt);
    burst_addr = {base[ADDR_W-1:BURST_W], low};
  endfunction

  assign selected = is_selected(chipSelectLowA, chipSelectLowB, chipSelectHigh);
  assign running = !clockEnableN && !sys_rst;
  assign curAddr = burst_addr(baseAddr, burstCnt, burstOrderSelect);
  assign nextAddr = burst_addr(next_baseAddr, next_burstCnt, burstOrderSelect);

  // Data phase of the owed write happens this cycle, whatever is loaded now
  assign writeNow = running && (op == OP_WRITE);

  // Decode of this cycle's control
  always_comb begin
    next_op = op;
    next_baseAddr = baseAddr;
    next_burstCnt = burstCnt;
    next_opStrobeN = opStrobeN;
    if (!advanceOrLoad) begin
      if (selected) begin
        // New load, legal in any cycle including mid-burst
        next_op = (readWriteSelect == RW_READ) ? OP_READ : OP_WRITE;
        next_baseAddr = address;
        next_burstCnt = BURST_CNT_RST;
        next_opStrobeN = byteWriteStrobeN;
      end else begin
        next_op = OP_IDLE;
      end
    end else if (op != OP_IDLE) begin
      // Advance ignores the selects; counter wraps after the fourth word
      next_burstCnt = burstCnt + BURST_STEP;
      next_opStrobeN = byteWriteStrobeN;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op <= OP_IDLE;
      baseAddr <= '0;
      burstCnt <= BURST_CNT_RST;
      opStrobeN <= '1;
    end else if (!clockEnableN) begin
      op <= next_op;
      baseAddr <= next_baseAddr;
      burstCnt <= next_burstCnt;
      opStrobeN <= next_opStrobeN;
    end
  end

  // Byte-lane writes into the array
  always_ff @(posedge clk) begin
    for (int lane = 0; lane < BYTE_N; lane++) begin
      if (writeNow && !opStrobeN[lane]) begin
        mem[curAddr][lane*BYTE_W +: BYTE_W] <= dataIn[lane*BYTE_W +: BYTE_W];
      end
    end
  end

  // Read word with the same-edge write merged in
  always_comb begin
    readWord = mem[nextAddr];
    if (writeNow && (curAddr == nextAddr)) begin
      for (int lane = 0; lane < BYTE_N; lane++) begin
        if (!opStrobeN[lane]) begin
          readWord[lane*BYTE_W +: BYTE_W] = dataIn[lane*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // Read data and bus drive for the next cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataOut <= DATA_W'(DOUT_RST);
      dataOutEnable <= 1'h0;
    end else if (!clockEnableN) begin
      dataOutEnable <= (next_op == OP_READ);
      if (next_op == OP_READ) begin
        dataOut <= readWord;
      end
    end
  end

  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_load;
    !clockEnableN && !advanceOrLoad && selected;
  endsequence

  sequence s_load_read;
    s_load and (readWriteSelect == RW_READ);
  endsequence

  sequence s_load_write;
    s_load and (readWriteSelect != RW_READ);
  endsequence

  sequence s_deselect;
    !clockEnableN && !advanceOrLoad && !selected;
  endsequence

  sequence s_advance;
    !clockEnableN && advanceOrLoad;
  endsequence

  property p_read_drives;
    s_load_read |=> dataOutEnable && (dataOut == mem[$past(address)]);
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("read load did not drive data next cycle");

  property p_write_releases;
    s_load_write |=> !dataOutEnable && (op == OP_WRITE);
  endproperty
  a_write_releases: assert property (p_write_releases)
    else $error("write load left the bus driven");

  property p_write_commit;
    writeNow && (opStrobeN == '0) |=> mem[$past(curAddr)] == $past(dataIn);
  endproperty
  a_write_commit: assert property (p_write_commit)
    else $error("owed write data not stored");

  property p_lane_kept;
    writeNow && opStrobeN[0] && (curAddr != nextAddr)
      |=> mem[$past(curAddr)][BYTE_W-1:0] == $past(mem[curAddr][BYTE_W-1:0]);
  endproperty
  a_lane_kept: assert property (p_lane_kept)
    else $error("disabled byte lane was written");

  property p_read_burst;
    s_load_read ##1 s_advance |=> dataOutEnable && (burstCnt == BURST_STEP);
  endproperty
  a_read_burst: assert property (p_read_burst)
    else $error("read advance did not step the burst");

  property p_burst_wrap;
    s_load ##1 s_advance [*4] |=> burstCnt == BURST_CNT_RST;
  endproperty
  a_burst_wrap: assert property (p_burst_wrap)
    else $error("burst counter did not wrap after four words");

  property p_deselect_noop;
    s_deselect ##1 s_advance |=> !dataOutEnable && (op == OP_IDLE);
  endproperty
  a_deselect_noop: assert property (p_deselect_noop)
    else $error("deselect followed by advance did not idle");

  property p_deselect_finishes;
    (op == OP_WRITE) and s_deselect |-> writeNow ##1 !dataOutEnable;
  endproperty
  a_deselect_finishes: assert property (p_deselect_finishes)
    else $error("pending write dropped at deselect");

  property p_high_select;
    !clockEnableN && !advanceOrLoad && !chipSelectHigh |=> op == OP_IDLE;
  endproperty
  a_high_select: assert property (p_high_select)
    else $error("selected with the high select low");

  property p_suspend;
    clockEnableN |=> $stable(dataOut) && $stable(dataOutEnable) && $stable(burstCnt)
      && $stable(op);
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("state changed while clock enable was high");

  property p_midburst_read;
    (op == OP_READ) and s_load_read |-> dataOutEnable ##1 dataOutEnable;
  endproperty
  a_midburst_read: assert property (p_midburst_read)
    else $error("mid-burst reload broke the read data stream");

  sequence s_read_burst;
    s_load_read ##1 s_advance [*3];
  endsequence

  sequence s_write_burst;
    s_load_write ##1 s_advance [*3];
  endsequence

  property p_write_advance;
    s_load_write ##1 s_advance
      |=> (op == OP_WRITE) && (burstCnt == BURST_STEP) && !dataOutEnable;
  endproperty
  a_write_advance: assert property (p_write_advance)
    else $error("write advance did not step the burst");

  property p_read_four;
    s_read_burst |=> dataOutEnable && (op == OP_READ)
      && (burstCnt == BURST_W'(BURST_LEN - 1)) && (dataOut == mem[curAddr]);
  endproperty
  a_read_four: assert property (p_read_four)
    else $error("fourth read word not delivered");

  property p_write_four;
    s_write_burst ##1 s_load |-> writeNow && (burstCnt == BURST_W'(BURST_LEN - 1))
      ##1 (burstCnt == BURST_CNT_RST) && (op != OP_IDLE);
  endproperty
  a_write_four: assert property (p_write_four)
    else $error("fourth write word not taken with the next load");

  property p_midburst_write;
    (op == OP_WRITE) and s_load_write
      |-> writeNow ##1 (op == OP_WRITE) && (burstCnt == BURST_CNT_RST);
  endproperty
  a_midburst_write: assert property (p_midburst_write)
    else $error("mid-burst write load lost the pending write");

  property p_burst_order;
    s_load ##1 s_advance
      |=> (curAddr[ADDR_W-1:BURST_W] == $past(address[ADDR_W-1:BURST_W], 2))
      && (curAddr[BURST_W-1:0] == ((burstOrderSelect == ORDER_INTERLEAVED)
        ? ($past(address[BURST_W-1:0], 2) ^ BURST_STEP)
        : BURST_W'($past(address[BURST_W-1:0], 2) + BURST_STEP)));
  endproperty
  a_burst_order: assert property (p_burst_order)
    else $error("second burst address out of order");

  property p_lane_written;
    writeNow && !opStrobeN[0]
      |=> mem[$past(curAddr)][BYTE_W-1:0] == $past(dataIn[BYTE_W-1:0]);
  endproperty
  a_lane_written: assert property (p_lane_written)
    else $error("enabled byte lane not written");

  property p_low_select;
    !clockEnableN && !advanceOrLoad && (chipSelectLowA || chipSelectLowB)
      |=> (op == OP_IDLE) && !dataOutEnable;
  endproperty
  a_low_select: assert property (p_low_select)
    else $error("selected with a low select high");

  property p_turnaround;
    s_load_write ##1 s_load_read |-> !dataOutEnable ##1 dataOutEnable;
  endproperty
  a_turnaround: assert property (p_turnaround)
    else $error("read after write did not turn the bus around");

  property p_turnaround_back;
    s_load_read ##1 s_load_write |-> dataOutEnable ##1 !dataOutEnable;
  endproperty
  a_turnaround_back: assert property (p_turnaround_back)
    else $error("write after read did not release the bus");

endmodule

/* tb/zts_ctrl_model.sv */
/*
  Bus master data side: drives write data in its owed cycle.
  Assumes the bench tells it when a write word is due.
*/
`timescale 1ns/1ps

module zts_ctrl_model #(
  parameter int DATA_W = 36
) (
  input wire logic clk,
  input wire logic wrDue,
  input wire logic [DATA_W-1:0] wrWord,
  output logic [DATA_W-1:0] dataIn
);
  logic [DATA_W-1:0] idle = '0;

  // Released bus toggles so stale data never matches
  always @(posedge clk) begin
    idle <= ~dataIn;
  end

  assign dataIn = wrDue ? wrWord : idle;
endmodule

/* tb/test_zts_sram_core.sv */
/*
  Self-checking random bench for the SRAM core with a reference model.
  Assumes package defaults: 17-bit address, four 9-bit lanes.
*/
`timescale 1ns/1ps

module test_zts_sram_core;
  import zts_pkg::*;
  localparam int NCYC = 2100;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [16:0] address = 17'h0;
  logic readWriteSelect = 1'h0, advanceOrLoad = 1'h0, clockEnableN = 1'h1;
  logic chipSelectLowA = 1'h1, chipSelectLowB = 1'h1, chipSelectHigh = 1'h0;
  logic [3:0] byteWriteStrobeN = 4'hf;
  logic burstOrderSelect = 1'h0, wrDue = 1'h0, dataOutEnable;
  logic [35:0] wrWord = 36'h0, dataIn, dataOut, exD = 36'h0;
  logic [35:0] mem [0:15];
  logic [36:0] q[$];
  logic [36:0] e;
  zts_op_t op = OP_IDLE;
  logic [16:0] base = 17'h0, pa = 17'h0;
  logic [1:0] cnt = 2'h0;
  logic [3:0] ps = 4'hf;
  logic ord = 1'h0, exEn = 1'h0, run = 1'h0;
  int seed = 32'he254;
  int mismatches = 0, checksDone = 0, r;

  always #50 clk = ~clk;

  zts_sram_core u_dut (.clk, .sys_rst, .address, .readWriteSelect, .advanceOrLoad,
    .chipSelectLowA, .chipSelectLowB, .chipSelectHigh, .clockEnableN, .byteWriteStrobeN,
    .burstOrderSelect, .dataIn, .dataOut, .dataOutEnable);
  zts_ctrl_model u_ctrl (.clk, .wrDue, .wrWord, .dataIn);

  task end_of_test;
    if (mismatches == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chkEn(input logic ex, input logic got);
    checksDone++;
    if (got !== ex) begin
      mismatches++;
      $display("CHECK FAILED dataOutEnable expected %b seen %b", ex, got);
    end
  endtask

  task chkData(input logic [35:0] ex, input logic [35:0] got);
    checksDone++;
    if (got !== ex) begin
      mismatches++;
      $display("CHECK FAILED dataOut expected %h seen %h", ex, got);
    end
  endtask

  // One bus cycle; model predicts the outputs of the following cycle
  task cyc(input logic c, v, w, input logic [2:0] cs, input logic [16:0] a,
           input logic [3:0] s);
    logic [35:0] d;
    int k;
    @(posedge clk);
    d = 36'({$random(seed), $random(seed)});
    clockEnableN <= c;
    advanceOrLoad <= v;
    readWriteSelect <= w;
    chipSelectLowA <= cs == 3'h1;
    chipSelectLowB <= cs == 3'h2;
    chipSelectHigh <= cs != 3'h3;
    address <= a;
    byteWriteStrobeN <= s;
    burstOrderSelect <= ord;
    wrDue <= op == OP_WRITE && !c;
    wrWord <= d;
    if (!c) begin
      if (op == OP_WRITE) begin
        for (k = 0; k < 4; k++) begin
          if (!ps[k]) begin
            mem[pa[3:0]][k*9+:9] = d[k*9+:9];
          end
        end
      end
      if (!v) begin
        op = (cs inside {3'h1, 3'h2, 3'h3}) ? OP_IDLE : (w ? OP_READ : OP_WRITE);
        base = a;
        cnt = 2'h0;
      end else if (op != OP_IDLE) begin
        cnt = cnt + 2'h1;
      end
      pa = {base[16:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
      ps = s;
      exEn = op == OP_READ;
      exD = mem[pa[3:0]];
    end
    q.push_back({exEn, exD});
  endtask

  always @(negedge clk) begin
    if (run && q.size() > 0) begin
      e = q.pop_front();
      chkEn(e[36], dataOutEnable);
      if (e[36]) begin
        chkData(e[35:0], dataOut);
      end
    end
  end

  initial begin
    #(NCYC * 200);
    mismatches++;
    end_of_test;
  end

  initial begin
    int i;
    repeat (4) @(posedge clk);
    sys_rst <= 1'h0;
    run <= 1'h1;
    q.push_back(37'h0);
    q.push_back(37'h0);
    // Fill the sixteen words used below with linear bursts
    for (i = 0; i < 16; i++) begin
      cyc(1'h0, i[1:0] != 2'h0, 1'h0, 3'h0, 17'(i), 4'h0);
    end
    for (i = 0; i < 2000; i++) begin
      if (i == 1000) begin
        cyc(1'h0, 1'h0, 1'h0, 3'h1, 17'h0, 4'hf);
        ord = 1'h1;
      end
      r = $random(seed);
      cyc(r[2:0] == 3'h0, r[3], r[4], r[7:5], {13'h0, r[11:8]}, r[15:12]);
    end
    repeat (3) @(posedge clk);
    end_of_test;
  end
endmodule
